// ---- verilog/multiplier_consts.vh ----
// Overview of operation
// RULE1 - Code 420: 16-bit signed factors give 32-bit product in two result words.
// RULE2 - Code 421: 32-bit signed factors give 64-bit product in four result words.
// RULE3 - Single-word signed multiply takes each factor from a stored word or a constant.
// RULE4 - Double-word signed multiply takes each factor from stored words or a constant.
// RULE5 - Code 424: two 4-digit BCD words give an 8-digit BCD product.
// RULE6 - Code 425: two 8-digit BCD factors give a 16-digit BCD product.
// RULE7 - Double-word BCD factors are unsigned decimal, with no sign digit.
// RULE8 - Single-word BCD multiply takes each factor from a stored word or a constant.
// RULE9 - Single-word BCD: error flag set when first factor has a non-decimal digit.
// RULE10 - Single-word BCD: error also on bad second factor; otherwise error cleared.
// RULE11 - Double-word BCD: error flag set if either first factor word is not decimal.
// RULE12 - Double-word BCD: error if either second factor word bad; otherwise cleared.
// RULE13 - All variants: zero flag set when whole product is zero, else cleared.
// RULE14 - Signed multiplies: negative flag equals product most significant bit.
// RULE15 - Program must hold execution condition true; otherwise no result words written.
// RULE16 - Least significant product word goes to first result word, ascending after.
// RULE17 - Any BCD digit above nine counts as invalid for the error checks.
// RULE18 - Signed multiplies always clear the error flag.
`ifndef MULTIPLIER_CONSTS_VH
`define MULTIPLIER_CONSTS_VH
`define OP_MUL_SIGNED 12'h1a4
`define OP_MUL_SIGNED_DOUBLE 12'h1a5
`define OP_MUL_BCD 12'h1a8
`define OP_MUL_BCD_DOUBLE 12'h1a9
`define BCD_TOP_DIGIT 3'h7
`define BCD_MAX_DIGIT 4'h9
`define BCD_ADJUST 5'h06
`endif

// ---- verilog/bcd_word_check.v ----
`include "multiplier_consts.vh"
module bcd_word_check
(
	// Word under test
	input wire [15:0] word,
	// High when any digit is above nine
	output wire invalid
);
	assign invalid = (word[3:0] > `BCD_MAX_DIGIT) || (word[7:4] > `BCD_MAX_DIGIT) ||
		(word[11:8] > `BCD_MAX_DIGIT) || (word[15:12] > `BCD_MAX_DIGIT); // [RULE17]
endmodule

// ---- verilog/signed_and_bcd_multiplier.v ----
`include "multiplier_consts.vh"
module signed_and_bcd_multiplier
(
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Instruction request
	input wire start,
	input wire exec_cond,
	input wire [11:0] op_code,
	// First factor
	input wire [31:0] first_factor_word,
	input wire [31:0] first_factor_const,
	input wire first_factor_sel_const,
	// Second factor
	input wire [31:0] second_factor_word,
	input wire [31:0] second_factor_const,
	input wire second_factor_sel_const,
	// Result words, least significant first
	output reg [15:0] result_word0,
	output reg [15:0] result_word1,
	output reg [15:0] result_word2,
	output reg [15:0] result_word3,
	output reg result_write,
	output reg result_double,
	// Status
	output reg busy,
	output reg done,
	output reg error_flag,
	output reg zero_result_flag,
	output reg negative_flag
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SHIFT = 2'd1;
	localparam ST_ADD = 2'd2;

	reg [1:0] state_reg;
	reg [31:0] md_reg;
	reg [31:0] mr_reg;
	reg [63:0] acc_reg;
	reg [2:0] idx_reg;
	reg [3:0] cnt_reg;
	reg dbl_reg;

	wire [31:0] first_factor;
	wire [31:0] second_factor;
	wire [3:0] bad_word;
	wire [63:0] sum;
	wire [16:0] carry;
	wire [31:0] prod_single;
	wire [63:0] prod_double;
	wire is_bcd;
	wire is_bcd_double;
	wire is_signed;
	wire is_signed_double;
	wire bcd_error;
	wire [3:0] cur_digit;

	// Factor source select
	assign first_factor = first_factor_sel_const ? first_factor_const : first_factor_word; // [RULE3] [RULE4] [RULE8]
	assign second_factor = second_factor_sel_const ? second_factor_const : second_factor_word; // [RULE3] [RULE4] [RULE8]

	assign is_signed = (op_code == `OP_MUL_SIGNED);
	assign is_signed_double = (op_code == `OP_MUL_SIGNED_DOUBLE);
	assign is_bcd = (op_code == `OP_MUL_BCD);
	assign is_bcd_double = (op_code == `OP_MUL_BCD_DOUBLE);

	// Signed products
	assign prod_single = $signed(first_factor[15:0]) * $signed(second_factor[15:0]); // [RULE1]
	assign prod_double = $signed(first_factor) * $signed(second_factor); // [RULE2]

	// Digit checks on each factor word
	bcd_word_check u_chk_first_lo
	(
		.word(first_factor[15:0]),
		.invalid(bad_word[0])
	);
	bcd_word_check u_chk_first_hi
	(
		.word(first_factor[31:16]),
		.invalid(bad_word[1])
	);
	bcd_word_check u_chk_second_lo
	(
		.word(second_factor[15:0]),
		.invalid(bad_word[2])
	);
	bcd_word_check u_chk_second_hi
	(
		.word(second_factor[31:16]),
		.invalid(bad_word[3])
	);

	assign bcd_error = is_bcd_double ? (|bad_word) : (bad_word[0] | bad_word[2]); // [RULE9] [RULE10] [RULE11] [RULE12]

	// Sixteen-digit decimal adder: accumulator plus first factor
	assign carry[0] = 1'b0;
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1)
		begin : digit_add
			wire [4:0] raw;
			wire [3:0] addend;
			wire [4:0] adj;
			assign addend = (g < 8) ? md_reg[(g % 8) * 4 +: 4] : 4'h0;
			assign raw = {1'b0, acc_reg[g * 4 +: 4]} + {1'b0, addend} + {4'h0, carry[g]};
			assign adj = raw + `BCD_ADJUST;
			assign carry[g + 1] = (raw > {1'b0, `BCD_MAX_DIGIT});
			assign sum[g * 4 +: 4] = carry[g + 1] ? adj[3:0] : raw[3:0];
		end
	endgenerate

	assign cur_digit = mr_reg[idx_reg * 4 +: 4];

	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_IDLE;
			md_reg <= 32'h0000_0000;
			mr_reg <= 32'h0000_0000;
			acc_reg <= 64'h0000_0000_0000_0000;
			idx_reg <= 3'h0;
			cnt_reg <= 4'h0;
			dbl_reg <= 1'b0;
			result_word0 <= 16'h0000;
			result_word1 <= 16'h0000;
			result_word2 <= 16'h0000;
			result_word3 <= 16'h0000;
			result_write <= 1'b0;
			result_double <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			error_flag <= 1'b0;
			zero_result_flag <= 1'b0;
			negative_flag <= 1'b0;
		end
		else
		begin
			result_write <= 1'b0;
			done <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (start && exec_cond) // [RULE15]
					begin
						if (is_signed)
						begin
							result_word0 <= prod_single[15:0]; // [RULE16]
							result_word1 <= prod_single[31:16];
							result_word2 <= 16'h0000;
							result_word3 <= 16'h0000;
							result_double <= 1'b0;
							result_write <= 1'b1;
							done <= 1'b1;
							error_flag <= 1'b0; // [RULE18]
							zero_result_flag <= (prod_single == 32'h0000_0000); // [RULE13]
							negative_flag <= prod_single[31]; // [RULE14]
						end
						else if (is_signed_double)
						begin
							result_word0 <= prod_double[15:0]; // [RULE16]
							result_word1 <= prod_double[31:16];
							result_word2 <= prod_double[47:32];
							result_word3 <= prod_double[63:48];
							result_double <= 1'b1;
							result_write <= 1'b1;
							done <= 1'b1;
							error_flag <= 1'b0; // [RULE18]
							zero_result_flag <= (prod_double == 64'h0000_0000_0000_0000); // [RULE13]
							negative_flag <= prod_double[63]; // [RULE14]
						end
						else if (is_bcd || is_bcd_double)
						begin
							if (bcd_error)
							begin
								error_flag <= 1'b1; // [RULE9] [RULE10] [RULE11] [RULE12]
								done <= 1'b1;
							end
							else
							begin
								// Unsigned decimal factors, upper word dropped for single width
								md_reg <= is_bcd_double ? first_factor : {16'h0000, first_factor[15:0]}; // [RULE7]
								mr_reg <= is_bcd_double ? second_factor : {16'h0000, second_factor[15:0]};
								dbl_reg <= is_bcd_double;
								acc_reg <= 64'h0000_0000_0000_0000;
								idx_reg <= `BCD_TOP_DIGIT;
								busy <= 1'b1;
								state_reg <= ST_SHIFT;
							end
						end
					end
				end
				ST_SHIFT:
				begin
					// Times ten, then add first factor once per digit unit
					acc_reg <= {acc_reg[59:0], 4'h0};
					cnt_reg <= cur_digit;
					state_reg <= ST_ADD;
				end
				ST_ADD:
				begin
					if (cnt_reg != 4'h0)
					begin
						acc_reg <= sum; // [RULE5] [RULE6]
						cnt_reg <= cnt_reg - 4'h1;
					end
					else if (idx_reg != 3'h0)
					begin
						idx_reg <= idx_reg - 3'h1;
						state_reg <= ST_SHIFT;
					end
					else
					begin
						result_word0 <= acc_reg[15:0]; // [RULE16]
						result_word1 <= acc_reg[31:16];
						result_word2 <= acc_reg[47:32];
						result_word3 <= acc_reg[63:48];
						result_double <= dbl_reg;
						result_write <= 1'b1;
						done <= 1'b1;
						busy <= 1'b0;
						error_flag <= 1'b0; // [RULE10] [RULE12]
						zero_result_flag <= (acc_reg == 64'h0000_0000_0000_0000); // [RULE13]
						state_reg <= ST_IDLE;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ---- verification/mul_asserts.sv ----
module mul_asserts
(
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Request
	input wire start,
	input wire exec_cond,
	input wire [11:0] op_code,
	// Results
	input wire [15:0] result_word0,
	input wire [15:0] result_word1,
	input wire [15:0] result_word2,
	input wire [15:0] result_word3,
	input wire result_write,
	input wire result_double,
	// Status
	input wire busy,
	input wire done,
	input wire error_flag,
	input wire zero_result_flag,
	input wire negative_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	wire take = start && exec_cond && !busy;
	wire [63:0] prod = {result_word3, result_word2, result_word1, result_word0};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	signed_write_a: assert property (take && op_code == 12'h1a4 |=> result_write && done && !error_flag)
		else $error("signed write missing");
	signed_neg_a: assert property (take && op_code == 12'h1a4 |=> negative_flag == result_word1[15])
		else $error("signed negative flag wrong");
	double_neg_a: assert property (take && op_code == 12'h1a5 |=> result_double && negative_flag == result_word3[15])
		else $error("double negative flag wrong");
	zero_flag_a: assert property (result_write |-> zero_result_flag == (prod == 64'h0))
		else $error("zero flag wrong");
	cond_off_a: assert property (start && !exec_cond && !busy |=> !result_write)
		else $error("write without condition");
	busy_done_a: assert property (busy |-> !done && !result_write)
		else $error("done while busy");
	bcd_done_a: assert property (take && (op_code == 12'h1a8 || op_code == 12'h1a9) |-> ##[1:89] done)
		else $error("decimal multiply too slow");
	error_nowrite_a: assert property (done && error_flag |-> !result_write)
		else $error("write on bad digit");
	single_high_a: assert property (result_write && !result_double |-> prod[63:32] == 32'h0)
		else $error("upper words not clear");
	cover property (take && op_code == 12'h1a5);
	cover property (done && result_double && !error_flag);
	cover property (done && error_flag);
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rstn, start, exec_cond, first_factor_sel_const, second_factor_sel_const;
	logic [11:0] op_code;
	logic [31:0] first_factor_word, first_factor_const, second_factor_word, second_factor_const;
	logic [15:0] result_word0, result_word1, result_word2, result_word3;
	logic result_write, result_double, busy, done, error_flag, zero_result_flag, negative_flag;
	int num_errors, check_count;
	signed_and_bcd_multiplier u_dut (.clk_sys, .rstn, .start, .exec_cond, .op_code, .first_factor_word,
		.first_factor_const, .first_factor_sel_const, .second_factor_word, .second_factor_const,
		.second_factor_sel_const, .result_word0, .result_word1, .result_word2, .result_word3, .result_write,
		.result_double, .busy, .done, .error_flag, .zero_result_flag, .negative_flag);
	always #12.5 clk_sys = ~clk_sys;
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [63:0] exp, got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic longint unsigned b2i(input logic [31:0] v);
		b2i = 0;
		for (int i = 7; i >= 0; i--)
			b2i = b2i * 10 + v[i*4 +: 4];
	endfunction
	function automatic logic [63:0] i2b(input longint unsigned v);
		for (int i = 0; i < 16; i++)
		begin
			i2b[i*4 +: 4] = 4'(v % 10);
			v = v / 10;
		end
	endfunction
	// Issue one request, unselected source holds the inverse value
	task automatic op(input logic [11:0] c, input logic [31:0] a, b, input logic sa, sb, ec);
		@(negedge clk_sys);
		op_code = c;
		first_factor_word = sa ? ~a : a;
		first_factor_const = sa ? a : ~a;
		second_factor_word = sb ? ~b : b;
		second_factor_const = sb ? b : ~b;
		first_factor_sel_const = sa;
		second_factor_sel_const = sb;
		exec_cond = ec;
		start = 1'h1;
		@(negedge clk_sys);
		start = 1'h0;
		for (int i = 0; i < 100 && !done; i++)
			@(negedge clk_sys);
		chk("done", 64'(ec), 64'(done));
		if (ec && !done)
			stop_test();
	endtask
	task automatic mul(input logic [11:0] c, input logic [31:0] a, b, input logic sa, sb);
		logic [63:0] e;
		logic signed [31:0] p32;
		logic signed [63:0] p64;
		logic bad;
		bad = 1'h0;
		for (int i = 0; i < (c[0] ? 8 : 4); i++)
			bad |= c[3] && (a[i*4 +: 4] > 4'h9 || b[i*4 +: 4] > 4'h9);
		p32 = $signed(a[15:0]) * $signed(b[15:0]);
		p64 = $signed(a) * $signed(b);
		e = c == 12'h1a4 ? {32'h0, p32} : c == 12'h1a5 ? p64 : i2b(b2i(a) * b2i(b));
		op(c, a, b, sa, sb, 1'h1);
		chk("error", 64'(bad), 64'(error_flag));
		chk("write", 64'(!bad), 64'(result_write));
		if (!bad)
		begin
			chk("product", e, {result_word3, result_word2, result_word1, result_word0});
			chk("double", 64'(c[0]), 64'(result_double));
			chk("zero", 64'(e == 64'h0), 64'(zero_result_flag));
			if (!c[3])
				chk("negative", 64'(e[c[0] ? 63 : 31]), 64'(negative_flag));
		end
	endtask
	task automatic t_bcd_err;
		mul(12'h1a8, 32'h00a0, 32'h0001, 1'h0, 1'h0);
		mul(12'h1a8, 32'h0001, 32'h000f, 1'h1, 1'h0);
		mul(12'h1a9, 32'hb000_0001, 32'h0001, 1'h0, 1'h1);
		mul(12'h1a9, 32'h0001, 32'h0000_00c0, 1'h0, 1'h0);
	endtask
	task automatic t_bcd;
		mul(12'h1a8, 32'h9999, 32'h9999, 1'h0, 1'h1);
		mul(12'h1a8, 32'h0000, 32'h1234, 1'h1, 1'h0);
		mul(12'h1a9, 32'h9999_9999, 32'h9999_9999, 1'h0, 1'h0);
		mul(12'h1a9, 32'h8765_4321, 32'h0000_0102, 1'h1, 1'h1);
	endtask
	task automatic t_signed;
		mul(12'h1a4, 32'h8000, 32'h7fff, 1'h0, 1'h1);
		mul(12'h1a4, 32'hffff, 32'hffff, 1'h1, 1'h0);
		mul(12'h1a4, 32'h1234, 32'h0000, 1'h0, 1'h0);
		mul(12'h1a5, 32'h8000_0000, 32'h8000_0000, 1'h1, 1'h1);
		mul(12'h1a5, 32'hffff_fffe, 32'h0001_0003, 1'h0, 1'h1);
	endtask
	task automatic t_cond_off;
		logic [63:0] keep;
		keep = {result_word3, result_word2, result_word1, result_word0};
		op(12'h1a4, 32'h0003, 32'h0005, 1'h0, 1'h0, 1'h0);
		chk("done", 64'h0, 64'(done));
		chk("kept", keep, {result_word3, result_word2, result_word1, result_word0});
	endtask
	initial
	begin
		{clk_sys, rstn, start, exec_cond, first_factor_sel_const, second_factor_sel_const} = 6'h00;
		{op_code, first_factor_word, first_factor_const, second_factor_word, second_factor_const} = 140'h0;
		num_errors = 0;
		check_count = 0;
		repeat (12) @(negedge clk_sys);
		rstn = 1'h1;
		t_bcd_err();
		t_bcd();
		t_signed();
		t_cond_off();
		stop_test();
	end
endmodule
bind signed_and_bcd_multiplier mul_asserts u_chk (.clk_sys, .rstn, .start, .exec_cond, .op_code, .result_word0,
	.result_word1, .result_word2, .result_word3, .result_write, .result_double, .busy, .done, .error_flag,
	.zero_result_flag, .negative_flag);
